//--- design/virtual_cpu_iface_priority_maint.sv
// Operation
// - No maintenance interrupt without global enable
// - Maintenance output is a level
// - Group enabled/disabled conditions, each with enable
// - Interrupt when no entry is pending
// - Interrupt after unmatched end-of-interrupt request
// - Underflow: zero or one valid entry
// - Interrupt while an entry saw end-of-interrupt
// - Maintenance identifier recommended as 25
// - Active bits: 128 or two^preemption bits
// - Highest active group by downward scan, lowest set bit kept
// - Highest active priority, 0xff when none
// - Report whether any active bit set
// - Drop clears lowest bit, group 0 first
// - Active search from entry 0, else -1
// - Minimum point keeps preemption top bits
// - Group field keeps top 7-point bits, top 8-point for non-secure group 1 without common point
// - Width code 000 is 16, 001 is 24
// - Identifier above 8191 has no active state
// - Direct candidate prioritized with list entries
// - Direct candidates only in non-secure state
// - Secure state withholds set commands
// - Without top level, any security state
// - Active bit marks undropped acknowledged interrupt
//
// The register offsets and the plain strobed port are this design's own decisions.
`default_nettype none
module virtual_cpu_iface_priority_maint #(
  parameter int         NLR         = 4,          // Number of list entries
  parameter int         PRI_BITS    = 5,          // Virtual priority bits
  parameter int         PRE_BITS    = 5,          // Virtual preemption bits
  parameter logic [2:0] ID_CODE     = 3'h0,       // Identifier width code
  parameter logic [7:0] MAINT_ID    = 8'h19       // Maintenance identifier
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_n,
  input  wire logic [7:0]             i_addr,     // Register byte address
  input  wire logic [31:0]            i_wdata,    // Write data
  input  wire logic                   i_wr,       // Write strobe
  input  wire logic                   i_rd,       // Read strobe
  output logic [31:0]                 o_rdata,    // Read data, cycle after strobe
  input  wire logic                   i_secure,   // Processor in secure state
  input  wire logic                   i_el3_present, // Highest exception level exists
  input  wire vcpu_pkg::direct_inj_t  i_direct,   // Forwarded direct candidate
  output logic                        o_maint,    // Maintenance interrupt level
  output vcpu_pkg::pend_out_t         o_pend      // Highest pending virtual interrupt
);
  // Implemented active-priority bits per group
  localparam int AP_BITS = (PRI_BITS == 8) ? 128 : (1 << PRE_BITS);
  localparam logic [127:0] AP_MASK = (AP_BITS == 128) ? {128{1'b1}} :
                                     ((128'h1 << AP_BITS) - 128'h1);
  // Minimum binary point mask keeps the preemption bits
  localparam logic [7:0] MIN_MASK = 8'(8'hff << (8 - PRE_BITS));
  localparam int IW = (NLR > 1) ? $clog2(NLR) : 1;
  localparam int CW = $clog2(NLR + 1);

  // Refuse shapes the logic cannot serve
  if (NLR < 1 || NLR > 16 || PRE_BITS < 5 || PRE_BITS > 7 ||
      PRI_BITS < PRE_BITS || PRI_BITS > 8) begin : g_bad_shape
    $error("virtual cpu interface parameters out of range");
  end
  // Only the two documented width codes exist
  if (ID_CODE != vcpu_pkg::ID_CODE_16 && ID_CODE != vcpu_pkg::ID_CODE_24) begin : g_bad_id
    $error("identifier width code invalid");
  end

  // Whole state of the block
  typedef struct packed {
    logic [8:0]                      hcr;     // Enable and condition enables
    logic [4:0]                      eoi_cnt; // Unmatched end-of-interrupt count
    logic [15:0]                     vmcr;    // Group enables and binary points
    logic [127:0]                    ap0;     // Group 0 active priorities
    logic [127:0]                    ap1;     // Group 1 active priorities
    vcpu_pkg::lr_entry_t [NLR-1:0]   lr;      // List entries
    logic [7:0]                      lookup;  // Last search result
    logic [8:0]                      prim;    // Priority and group for masking
    logic [31:0]                     rdata;   // Read data
    logic                            maint;   // Maintenance level
    vcpu_pkg::pend_out_t             pend;    // Pending selection
  } state_t;

  state_t s_r;   // Registered state
  state_t s_nxt; // Next state

  // Derived signals
  logic [127:0]      ap0_i;      // Implemented group 0 bits
  logic [127:0]      ap1_i;      // Implemented group 1 bits
  logic              ap_any;     // Any active bit
  logic [7:0]        hi_idx;     // Lowest set index
  vcpu_pkg::grp_t    hi_grp;     // Highest active group
  logic [CW-1:0]     valid_cnt;  // Valid entries
  logic              any_pend;   // Some entry pending
  logic              any_eoi;    // Some entry saw end-of-interrupt
  logic              best_ok;    // Pending entry found
  logic [IW-1:0]     best_idx;   // Best pending entry
  logic [7:0]        best_prio;  // Its priority
  logic              hit;        // Active entry matches write data
  logic [IW-1:0]     hit_idx;    // First matching entry
  logic              direct_ok;  // Direct candidate may compete
  logic [7:0]        cond;       // Raw maintenance conditions
  logic [7:0]        cond_en;    // Conditions gated by their enables
  logic              maint_lvl;  // Level before the register
  logic [3:0]        grp_shift;  // Zero bits below the group field
  logic [7:0]        grp_bits;   // Group priority field
  logic [7:0]        min_bits;   // Minimum point priority group
  logic [31:0]       rd_val;     // Read multiplexer
  logic [31:0]       vtr_val;    // Type info word
  logic              lr_sel;     // Address in list entry range
  logic [3:0]        lr_w;       // Addressed list entry

  // Only implemented bits take part
  assign ap0_i = s_r.ap0 & AP_MASK;
  assign ap1_i = s_r.ap1 & AP_MASK;

  // Lowest set index across both groups
  lowest_set_finder #(
    .W(128)
  ) u_find (
    .i_vec  (ap0_i | ap1_i),
    .o_found(ap_any),
    .o_index(hi_idx)
  );

  // Group 0 wins at the first set index
  always_comb begin
    if (!ap_any) begin
      hi_grp = vcpu_pkg::GRP_NONE;
    end else if (ap0_i[hi_idx[6:0]]) begin
      hi_grp = vcpu_pkg::GRP_ZERO;
    end else begin
      hi_grp = vcpu_pkg::GRP_ONE;
    end
  end

  // Scan of list entries
  always_comb begin
    valid_cnt = '0;
    any_pend  = 1'b0;
    any_eoi   = 1'b0;
    best_ok   = 1'b0;
    best_idx  = '0;
    best_prio = vcpu_pkg::NO_PRIO;
    hit       = 1'b0;
    hit_idx   = '0;
    for (int i = 0; i < NLR; i++) begin
      // Count valid entries
      if (s_r.lr[i].state != vcpu_pkg::ST_INV) begin
        valid_cnt = CW'(valid_cnt + 1'b1);
      end
      // Pending bit of the state
      if (s_r.lr[i].state[0]) begin
        any_pend = 1'b1;
      end
      if (s_r.lr[i].eoi_seen) begin
        any_eoi = 1'b1;
      end
      // Best pending entry of an enabled group, lower index on ties
      if (s_r.lr[i].state[0] &&
          s_r.vmcr[s_r.lr[i].group ? vcpu_pkg::VMCR_G1EN : vcpu_pkg::VMCR_G0EN] &&
          (!best_ok || s_r.lr[i].prio < best_prio)) begin
        best_ok   = 1'b1;
        best_idx  = IW'(i);
        best_prio = s_r.lr[i].prio;
      end
      // First active entry matching the written identifier
      if (!hit && s_r.lr[i].state[1] && s_r.lr[i].vid < vcpu_pkg::LPI_MIN_VID &&
          s_r.lr[i].vid == i_wdata[15:0]) begin
        hit     = 1'b1;
        hit_idx = IW'(i);
      end
    end
  end

  // Direct candidates compete only where security state allows
  assign direct_ok = i_direct.valid && s_r.vmcr[vcpu_pkg::VMCR_G1EN] &&
                     (!i_el3_present || !i_secure);

  // Maintenance conditions in maintenance-state order
  always_comb begin
    cond                    = '0;
    cond[vcpu_pkg::MS_EOI]   = any_eoi;
    cond[vcpu_pkg::MS_UNDER] = valid_cnt <= CW'(1);
    cond[vcpu_pkg::MS_NOMAT] = s_r.eoi_cnt != 5'h00;
    cond[vcpu_pkg::MS_NOPND] = !any_pend;
    cond[vcpu_pkg::MS_G0E]   = s_r.vmcr[vcpu_pkg::VMCR_G0EN];
    cond[vcpu_pkg::MS_G0D]   = !s_r.vmcr[vcpu_pkg::VMCR_G0EN];
    cond[vcpu_pkg::MS_G1E]   = s_r.vmcr[vcpu_pkg::VMCR_G1EN];
    cond[vcpu_pkg::MS_G1D]   = !s_r.vmcr[vcpu_pkg::VMCR_G1EN];
  end
  assign cond_en   = cond & s_r.hcr[vcpu_pkg::HCR_MIE_MSB:vcpu_pkg::HCR_MIE_LSB];
  assign maint_lvl = s_r.hcr[vcpu_pkg::HCR_EN] && (|cond_en);

  // Group field zero count: common point or group 0 uses point 0
  always_comb begin
    if (!s_r.prim[8] || s_r.vmcr[vcpu_pkg::VMCR_CBPR]) begin
      grp_shift = {1'b0, s_r.vmcr[vcpu_pkg::VMCR_BP0_LSB +: 3]} + 4'h1;
    end else if (i_secure) begin
      grp_shift = {1'b0, s_r.vmcr[vcpu_pkg::VMCR_BP1_LSB +: 3]} + 4'h1;
    end else begin
      grp_shift = {1'b0, s_r.vmcr[vcpu_pkg::VMCR_BP1_LSB +: 3]}; // Point minus one
    end
  end
  assign grp_bits = s_r.prim[7:0] & 8'(8'hff << grp_shift);
  assign min_bits = s_r.prim[7:0] & MIN_MASK;

  // Type info, maintenance identifier in the top byte
  assign vtr_val = {MAINT_ID, 4'h0, 4'(NLR - 1), 1'b0, 3'(PRI_BITS - 1),
                    1'b0, 3'(PRE_BITS - 1), 5'h00, ID_CODE};

  // List entry window decode
  assign lr_sel = i_addr >= vcpu_pkg::OFF_LR && i_addr < 8'(vcpu_pkg::OFF_LR + 4 * NLR);
  assign lr_w   = i_addr[5:2];

  // Read multiplexer, unmapped reads as zero
  always_comb begin
    if (i_addr == vcpu_pkg::OFF_HCR) begin
      rd_val = {s_r.eoi_cnt, 18'h00000, s_r.hcr};
    end else if (i_addr == vcpu_pkg::OFF_VMCR) begin
      rd_val = {16'h0000, s_r.vmcr};
    end else if (i_addr == vcpu_pkg::OFF_VTR) begin
      rd_val = vtr_val;
    end else if (i_addr == vcpu_pkg::OFF_MAINT) begin
      rd_val = {24'h000000, cond_en};
    end else if (i_addr == vcpu_pkg::OFF_ACT) begin
      rd_val = {15'h0000, ap_any, 6'h00, hi_grp, hi_idx};
    end else if (i_addr == vcpu_pkg::OFF_LOOK) begin
      rd_val = {24'h000000, s_r.lookup};
    end else if (i_addr == vcpu_pkg::OFF_PRIM) begin
      rd_val = {16'h0000, grp_bits, min_bits};
    end else if (i_addr[7:4] == vcpu_pkg::OFF_AP0[7:4]) begin
      rd_val = ap0_i[32 * i_addr[3:2] +: 32];
    end else if (i_addr[7:4] == vcpu_pkg::OFF_AP1[7:4]) begin
      rd_val = ap1_i[32 * i_addr[3:2] +: 32];
    end else if (lr_sel) begin
      rd_val = s_r.lr[lr_w[IW-1:0]];
    end else begin
      rd_val = 32'h00000000;
    end
  end

  // Next state
  always_comb begin
    s_nxt       = s_r;
    s_nxt.rdata = 32'h00000000;
    s_nxt.maint = maint_lvl;
    // Overall pending: direct candidate wins only when strictly higher
    if (direct_ok && (!best_ok || i_direct.prio < best_prio)) begin
      s_nxt.pend = {1'b1, 1'b1, i_direct.prio, i_direct.vid};
    end else if (best_ok) begin
      s_nxt.pend = {1'b1, 1'b0, best_prio, s_r.lr[best_idx].vid};
    end else begin
      s_nxt.pend = '0;
    end
    // Register writes
    if (i_wr) begin
      if (i_addr == vcpu_pkg::OFF_HCR) begin
        s_nxt.hcr     = i_wdata[8:0];
        s_nxt.eoi_cnt = i_wdata[vcpu_pkg::HCR_CNT_LSB +: 5];
      end else if (i_addr == vcpu_pkg::OFF_VMCR) begin
        s_nxt.vmcr = i_wdata[15:0];
      end else if (i_addr == vcpu_pkg::OFF_EOI) begin
        // Matching entry leaves active and records the request
        if (hit) begin
          s_nxt.lr[hit_idx].state    = s_r.lr[hit_idx].state & vcpu_pkg::ST_PEND;
          s_nxt.lr[hit_idx].eoi_seen = 1'b1;
        end else if (s_r.eoi_cnt != 5'h1f) begin
          s_nxt.eoi_cnt = s_r.eoi_cnt + 5'h01;
        end
      end else if (i_addr == vcpu_pkg::OFF_DROP) begin
        // Clear one bit, group 0 preferred at equal index
        if (ap_any && ap0_i[hi_idx[6:0]]) begin
          s_nxt.ap0[hi_idx[6:0]] = 1'b0;
        end else if (ap_any) begin
          s_nxt.ap1[hi_idx[6:0]] = 1'b0;
        end
      end else if (i_addr == vcpu_pkg::OFF_LOOK) begin
        s_nxt.lookup = hit ? 8'(hit_idx) : vcpu_pkg::NO_MATCH;
      end else if (i_addr == vcpu_pkg::OFF_PRIM) begin
        s_nxt.prim = i_wdata[8:0];
      end else if (i_addr[7:4] == vcpu_pkg::OFF_AP0[7:4]) begin
        // A set bit is an acknowledged, undropped group 0 interrupt
        s_nxt.ap0[32 * i_addr[3:2] +: 32] = i_wdata & AP_MASK[32 * i_addr[3:2] +: 32];
      end else if (i_addr[7:4] == vcpu_pkg::OFF_AP1[7:4]) begin
        s_nxt.ap1[32 * i_addr[3:2] +: 32] = i_wdata & AP_MASK[32 * i_addr[3:2] +: 32];
      end else if (lr_sel) begin
        s_nxt.lr[lr_w[IW-1:0]] = i_wdata;
        // Locality-specific identifiers never hold the active state
        if (i_wdata[15:0] >= vcpu_pkg::LPI_MIN_VID) begin
          s_nxt.lr[lr_w[IW-1:0]].state[1] = 1'b0;
        end
      end
    end
    // Read data for the following cycle
    if (i_rd) begin
      s_nxt.rdata = rd_val;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s_r        <= '0;
      s_r.hcr    <= vcpu_pkg::HCR_RST;
      s_r.vmcr   <= vcpu_pkg::VMCR_RST;
      s_r.lookup <= vcpu_pkg::NO_MATCH;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state
  assign o_rdata = s_r.rdata;
  assign o_maint = s_r.maint;
  assign o_pend  = s_r.pend;

  // Checks, all in the one clock domain
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  maint_gated_a:
    assert property (!s_r.hcr[vcpu_pkg::HCR_EN] |=> !o_maint)
      else $error("maintenance raised while globally disabled");

  maint_follows_a:
    assert property (maint_lvl |=> o_maint)
      else $error("maintenance level not registered");

  maint_holds_a:
    assert property (o_maint && $stable(s_r.hcr) && $stable(s_r.vmcr) &&
                     $stable(s_r.lr) && $stable(s_r.eoi_cnt) |=> o_maint)
      else $error("maintenance level dropped while its cause held");

  underflow_raise_a:
    assert property (s_r.hcr[vcpu_pkg::HCR_EN] && s_r.hcr[vcpu_pkg::HCR_MIE_LSB + 1] &&
                     valid_cnt <= CW'(1) |=> o_maint)
      else $error("underflow did not raise maintenance");

  drop_one_a:
    assert property (i_wr && i_addr == vcpu_pkg::OFF_DROP && ap_any |=>
                     $countones({ap0_i, ap1_i}) == $past($countones({ap0_i, ap1_i})) - 1)
      else $error("priority drop did not clear exactly one bit");

  no_active_prio_a:
    assert property (!ap_any |-> hi_idx == vcpu_pkg::NO_PRIO && hi_grp == vcpu_pkg::GRP_NONE)
      else $error("highest priority not all ones when none active");

  search_miss_a:
    assert property (i_wr && i_addr == vcpu_pkg::OFF_LOOK && !hit |=>
                     s_r.lookup == vcpu_pkg::NO_MATCH)
      else $error("failed search did not return minus one");

  secure_withhold_a:
    assert property (i_el3_present && i_secure |=> !(o_pend.valid && o_pend.direct))
      else $error("direct candidate selected in secure state");

  nomatch_count_a:
    assert property (i_wr && i_addr == vcpu_pkg::OFF_EOI && !hit |=> s_r.eoi_cnt != 5'h00)
      else $error("unmatched end-of-interrupt not recorded");
endmodule
`default_nettype wire

//--- design/vcpu_pkg.sv
`default_nettype none
package vcpu_pkg;
  // Register offsets, byte addresses
  localparam logic [7:0] OFF_HCR   = 8'h00; // Hypervisor virtual control
  localparam logic [7:0] OFF_VMCR  = 8'h04; // Virtual machine control
  localparam logic [7:0] OFF_VTR   = 8'h08; // Virtual type info, read only
  localparam logic [7:0] OFF_MAINT = 8'h0c; // Maintenance state, read only
  localparam logic [7:0] OFF_EOI   = 8'h10; // End-of-interrupt request, write only
  localparam logic [7:0] OFF_DROP  = 8'h14; // Priority drop, write only
  localparam logic [7:0] OFF_ACT   = 8'h18; // Highest active group/priority
  localparam logic [7:0] OFF_LOOK  = 8'h1c; // Active entry search
  localparam logic [7:0] OFF_PRIM  = 8'h20; // Priority group masking
  localparam logic [7:0] OFF_AP0   = 8'h40; // Active priority group 0, 4 words
  localparam logic [7:0] OFF_AP1   = 8'h50; // Active priority group 1, 4 words
  localparam logic [7:0] OFF_LR    = 8'h80; // List entries, one word each

  // Hypervisor control fields
  localparam int HCR_EN      = 0;  // Global enable
  localparam int HCR_MIE_LSB = 1;  // Condition enables, maintenance-state order
  localparam int HCR_MIE_MSB = 8;
  localparam int HCR_CNT_LSB = 27; // Unmatched end-of-interrupt count
  localparam logic [8:0] HCR_RST = 9'h000;

  // Maintenance condition positions
  localparam int MS_EOI   = 0; // Entry received end-of-interrupt
  localparam int MS_UNDER = 1; // Zero or one valid entry
  localparam int MS_NOMAT = 2; // Unmatched end-of-interrupt seen
  localparam int MS_NOPND = 3; // No pending entry
  localparam int MS_G0E   = 4;
  localparam int MS_G0D   = 5;
  localparam int MS_G1E   = 6;
  localparam int MS_G1D   = 7;

  // Virtual machine control fields
  localparam int VMCR_G0EN    = 0;
  localparam int VMCR_G1EN    = 1;
  localparam int VMCR_CBPR    = 4;
  localparam int VMCR_BP0_LSB = 8;
  localparam int VMCR_BP1_LSB = 12;
  localparam logic [15:0] VMCR_RST = 16'h0000;

  // Type info fields
  localparam int VTR_PRE_LSB = 8;
  localparam int VTR_PRI_LSB = 12;
  localparam int VTR_NLR_LSB = 16;
  localparam int VTR_INT_LSB = 24;

  // Identifier width codes
  localparam logic [2:0] ID_CODE_16 = 3'h0;
  localparam logic [2:0] ID_CODE_24 = 3'h1;

  // List entry states
  localparam logic [1:0] ST_INV  = 2'h0;
  localparam logic [1:0] ST_PEND = 2'h1;
  localparam logic [1:0] ST_ACT  = 2'h2;

  // First locality-specific identifier
  localparam logic [15:0] LPI_MIN_VID = 16'h2000;
  localparam logic [7:0]  NO_MATCH    = 8'hff;
  localparam logic [7:0]  NO_PRIO     = 8'hff;

  // Highest active group result
  typedef enum logic [1:0] {
    GRP_NONE = 2'h0,
    GRP_ZERO = 2'h1,
    GRP_ONE  = 2'h2
  } grp_t;

  // One list entry word
  typedef struct packed {
    logic [1:0]  state;
    logic        eoi_seen;
    logic        group;
    logic [3:0]  rsvd;
    logic [7:0]  prio;
    logic [15:0] vid;
  } lr_entry_t;

  // Directly injected candidate from the redistribution side
  typedef struct packed {
    logic        valid;
    logic [7:0]  prio;
    logic [15:0] vid;
  } direct_inj_t;

  // Overall highest pending virtual interrupt
  typedef struct packed {
    logic        valid;
    logic        direct;
    logic [7:0]  prio;
    logic [15:0] vid;
  } pend_out_t;
endpackage
`default_nettype wire

//--- design/lowest_set_finder.sv
`default_nettype none
// Finds the lowest set bit index of a vector
module lowest_set_finder #(
  parameter int W = 128
) (
  input  wire logic [W-1:0] i_vec,
  output logic              o_found,
  output logic [7:0]        o_index
);
  // Index must fit eight bits
  if (W < 1 || W > 256) begin : g_bad_width
    $error("lowest_set_finder width out of range");
  end

  // Scan downward so the lowest set bit is kept last
  always_comb begin
    o_found = 1'b0;
    o_index = 8'hff;
    for (int i = W - 1; i >= 0; i--) begin
      if (i_vec[i]) begin
        o_found = 1'b1;
        o_index = 8'(i);
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/redist_model.sv
`default_nettype none
// Redistribution side: forwards one direct candidate
module redist_model (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,  // Reset, active low
  input  wire logic             i_offer,  // Candidate present
  input  wire logic [7:0]       i_prio,   // Candidate priority
  input  wire logic [15:0]      i_vid,    // Candidate identifier
  output vcpu_pkg::direct_inj_t o_direct  // Forwarded candidate
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sends in any security state; idle fields toggle so stale values never match
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_direct <= '0;
    end else begin
      o_direct.valid <= i_offer;
      o_direct.prio  <= i_offer ? i_prio : ~o_direct.prio;
      o_direct.vid   <= i_offer ? i_vid : ~o_direct.vid;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // One maintenance case: control, group enables, condition word, level
  typedef struct packed {
    logic [8:0] hcr;
    logic [1:0] vmcr;
    logic [7:0] ms;
    logic       lvl;
  } row_t;
  localparam row_t ROWS [10] = '{
    {9'h005, 2'h0, 8'h02, 1'b1}, {9'h004, 2'h0, 8'h00, 1'b0},
    {9'h009, 2'h0, 8'h00, 1'b0}, {9'h011, 2'h0, 8'h08, 1'b1},
    {9'h021, 2'h1, 8'h10, 1'b1}, {9'h041, 2'h0, 8'h20, 1'b1},
    {9'h081, 2'h2, 8'h40, 1'b1}, {9'h101, 2'h0, 8'h80, 1'b1},
    {9'h003, 2'h0, 8'h00, 1'b0}, {9'h041, 2'h1, 8'h00, 1'b0}};
  logic                  i_clk_sys = 1'b0;  // System clock
  logic                  i_rst_n   = 1'b0;  // Reset, active low
  logic [7:0]            i_addr    = 8'h00; // Register address
  logic [31:0]           i_wdata   = 32'h0; // Write data
  logic                  i_wr      = 1'b0;  // Write strobe
  logic                  i_rd      = 1'b0;  // Read strobe
  logic                  i_secure  = 1'b0;  // Secure state
  logic                  i_el3     = 1'b1;  // Top level present
  logic                  offer     = 1'b0;  // Partner candidate present
  logic [7:0]            dprio     = 8'h00; // Partner priority
  logic [15:0]           dvid      = 16'h0; // Partner identifier
  logic [31:0]           o_rdata;           // Read data
  logic                  o_maint;           // Maintenance level
  vcpu_pkg::direct_inj_t dir;               // Forwarded candidate
  vcpu_pkg::pend_out_t   o_pend;            // Highest pending
  int                    miscompares = 0;   // Mismatches
  int                    num_checks  = 0;   // Comparisons

  // 250 MHz clock
  always #2 i_clk_sys = ~i_clk_sys;

  redist_model partner (.i_clk(i_clk_sys), .i_rst_n(i_rst_n), .i_offer(offer),
    .i_prio(dprio), .i_vid(dvid), .o_direct(dir));
  virtual_cpu_iface_priority_maint dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_secure(i_secure), .i_el3_present(i_el3), .i_direct(dir), .o_maint(o_maint),
    .o_pend(o_pend));

  // Verdict and end of run
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compare the level output
  task automatic chm(input logic exp);
    chk({31'h0, o_maint}, {31'h0, exp});
  endtask
  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  // One-cycle read, data checked in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  // Wait cycles, then settle past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // Reset for 10 cycles
  task automatic rst;
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
  endtask
  // Partner offer and security state, then pending result
  task automatic dj(input logic o, input logic [7:0] p, input logic s, input logic e,
                    input logic [31:0] exp);
    @(posedge i_clk_sys);
    offer    <= o;
    dprio    <= p;
    dvid     <= 16'h2005;
    i_secure <= s;
    i_el3    <= e;
    wt(3);
    chk({6'h0, o_pend}, exp);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    miscompares++;
    stop_test();
  end

  // Main sequence
  initial begin
    rst();
    foreach (ROWS[k]) begin
      wr(vcpu_pkg::OFF_VMCR, {30'h0, ROWS[k].vmcr});
      wr(vcpu_pkg::OFF_HCR, {23'h0, ROWS[k].hcr});
      wt(2);
      chm(ROWS[k].lvl); // Gated level
      if (ROWS[k].hcr[0]) rdc(vcpu_pkg::OFF_MAINT, {24'h0, ROWS[k].ms}); // Word
      chm(ROWS[k].lvl); // Level still held
    end
    rst();
    wt(1);
    chm(1'b0); // Quiet after reset
    rdc(vcpu_pkg::OFF_VTR, 32'h1903_4400); // Type info
    rdc(vcpu_pkg::OFF_LOOK, 32'h0000_00ff); // Search reset value
    rdc(8'hfc, 32'h0);
    wr(vcpu_pkg::OFF_LR, 32'h4040_0020);
    wr(vcpu_pkg::OFF_LR + 8'h04, 32'h8030_0021);
    wr(vcpu_pkg::OFF_LR + 8'h08, 32'h8050_2000);
    rdc(vcpu_pkg::OFF_LR + 8'h08, 32'h0050_2000); // No active state
    wr(vcpu_pkg::OFF_LOOK, 32'h21);
    rdc(vcpu_pkg::OFF_LOOK, 32'h1); // Active match
    wr(vcpu_pkg::OFF_LOOK, 32'h2000);
    rdc(vcpu_pkg::OFF_LOOK, 32'hff); // No match
    wr(vcpu_pkg::OFF_VMCR, 32'h3);
    dj(1'b0, 8'h00, 1'b0, 1'b1, 32'h0240_0020); // Entry alone
    dj(1'b1, 8'h10, 1'b0, 1'b1, 32'h0310_2005); // Direct wins
    dj(1'b1, 8'h10, 1'b1, 1'b1, 32'h0240_0020); // Withheld
    dj(1'b1, 8'h10, 1'b1, 1'b0, 32'h0310_2005); // Any state
    dj(1'b1, 8'h40, 1'b0, 1'b1, 32'h0240_0020); // Tie keeps entry
    dj(1'b0, 8'h00, 1'b0, 1'b1, 32'h0240_0020); // Offer withdrawn
    wr(vcpu_pkg::OFF_HCR, 32'h3);
    wt(2);
    chm(1'b0); // No flag yet
    wr(vcpu_pkg::OFF_EOI, 32'h21);
    wt(2);
    chm(1'b1); // Flag raised
    rdc(vcpu_pkg::OFF_LR + 8'h04, 32'h2030_0021); // Active cleared
    wr(vcpu_pkg::OFF_HCR, 32'h9);
    wt(2);
    chm(1'b0); // Count zero
    wr(vcpu_pkg::OFF_EOI, 32'h99);
    wt(2);
    chm(1'b1); // Unmatched seen
    rdc(vcpu_pkg::OFF_HCR, 32'h0800_0009); // Count one
    wr(vcpu_pkg::OFF_HCR, 32'h5);
    wt(2);
    chm(1'b1); // One valid entry
    wr(vcpu_pkg::OFF_LR + 8'h0c, 32'h4060_0030);
    wt(2);
    chm(1'b0); // Two valid entries
    wr(vcpu_pkg::OFF_AP0, 32'h10);
    wr(vcpu_pkg::OFF_AP1, 32'h14);
    wr(vcpu_pkg::OFF_AP0 + 8'h04, 32'hffff_ffff);
    rdc(vcpu_pkg::OFF_AP0 + 8'h04, 32'h0); // Unimplemented word
    rdc(vcpu_pkg::OFF_ACT, 32'h0001_0202); // Group one lowest
    wr(vcpu_pkg::OFF_DROP, 32'h0);
    rdc(vcpu_pkg::OFF_ACT, 32'h0001_0104); // Group zero at tie
    wr(vcpu_pkg::OFF_DROP, 32'h0);
    rdc(vcpu_pkg::OFF_AP0, 32'h0); // Group zero dropped first
    rdc(vcpu_pkg::OFF_AP1, 32'h10); // One bit only
    wr(vcpu_pkg::OFF_DROP, 32'h0);
    rdc(vcpu_pkg::OFF_ACT, 32'h0000_00ff); // Nothing active
    wr(vcpu_pkg::OFF_VMCR, 32'h3303);
    wr(vcpu_pkg::OFF_PRIM, 32'hff);
    rdc(vcpu_pkg::OFF_PRIM, 32'hf0f8); // Group zero point
    wr(vcpu_pkg::OFF_PRIM, 32'h1ff);
    rdc(vcpu_pkg::OFF_PRIM, 32'hf8f8); // Non-secure point minus one
    wr(vcpu_pkg::OFF_VMCR, 32'h3313);
    rdc(vcpu_pkg::OFF_PRIM, 32'hf0f8); // Common point
    stop_test();
  end
endmodule
`default_nettype wire
